// *** rtl/omcs_ctrl.sv ***
// Control pins, fault latch and two-wire memory slave of the module.
// Assumes pins are asynchronous to clk_sys and the bus is slow against it.
`timescale 1ns/100ps
`default_nettype none
module omcs_ctrl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic txDisablePin,
    input wire logic laserFaultDet,
    input wire logic rxModAbsent,
    input wire omcs_pkg::omcs_mon_s monitors,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic txLaserEn,
    output logic txFaultOut,
    output logic txFaultOe,
    output logic receiveSignalLost
);
    import omcs_pkg::*;

    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    logic pinPrev_q, sclPrev_q, sdaPrev_q;
    logic softDis_q, faultLat_q, laserOn_q, rxLost_q, lowDrive_q, sdaOe_q;
    logic faultOe_q;
    logic faultLat_d, laserOn_d;
    omcs_state_e state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q, ptr_q;
    logic memSel_q, readMode_q, masterAck_q;
    logic [7:0] idMem [256];
    logic [7:0] diagMem [256];

    // Two-stage synchronisers; shutdown lane resets high so laser starts off
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_q <= SYNC_RST;
            syncB_q <= SYNC_RST;
        end else begin
            syncA_q <= {sdaIn, sclIn, rxModAbsent, laserFaultDet,
                        txDisablePin};
            syncB_q <= syncA_q;
        end
    end

    wire pinS = syncB_q[IX_TXDIS];
    wire faultS = syncB_q[IX_FAULT];
    wire rxAbsS = syncB_q[IX_RXABS];
    wire sclS = syncB_q[IX_SCL];
    wire sdaS = syncB_q[IX_SDA];

    // Bus edge and framing detection
    wire sclRise = sclS && !sclPrev_q;
    wire sclFall = !sclS && sclPrev_q;
    wire startDet = sclS && sclPrev_q && sdaPrev_q && !sdaS;
    wire stopDet = sclS && sclPrev_q && !sdaPrev_q && sdaS;
    wire byteDone = (bitCnt_q == BITS_PER_BYTE);
    wire pinFall = pinPrev_q && !pinS;

    // Fault latch: a new fault wins over the clearing pin toggle
    assign faultLat_d = faultS ? 1'b1 :
                        (pinFall ? 1'b0 : faultLat_q);
    assign laserOn_d = !(pinS || softDis_q ||
                         faultLat_q || faultS);

    // Status byte built live from current state on every read
    wire [7:0] statusByte = {pinS, softDis_q, 3'h0, faultLat_q, rxLost_q, 1'b0};

    function automatic logic [7:0] readByte(input logic diag,
                                             input logic [7:0] a,
                                             input omcs_mon_s m,
                                             input logic [7:0] st,
                                             input logic [7:0] idB,
                                             input logic [7:0] dgB);
        logic [7:0] r;
        r = dgB;
        if (!diag) r = idB;
        else if (a == STATUS_OFS) r = st;
        else if (a == MON_TEMP_OFS) r = m.temp[15:8];
        else if (a == MON_TEMP_OFS + 8'h01) r = m.temp[7:0];
        else if (a == MON_VCC_OFS) r = m.vcc[15:8];
        else if (a == MON_VCC_OFS + 8'h01) r = m.vcc[7:0];
        else if (a == MON_BIAS_OFS) r = m.bias[15:8];
        else if (a == MON_BIAS_OFS + 8'h01) r = m.bias[7:0];
        else if (a == MON_TXPWR_OFS) r = m.txPower[15:8];
        else if (a == MON_TXPWR_OFS + 8'h01) r = m.txPower[7:0];
        else if (a == MON_RXPWR_OFS) r = m.rxPower[15:8];
        else if (a == MON_RXPWR_OFS + 8'h01) r = m.rxPower[7:0];
        return r;
    endfunction

    wire [7:0] rdByte = readByte(memSel_q, ptr_q, monitors, statusByte,
                                 idMem[ptr_q], diagMem[ptr_q]);
    wire addrId = (shift_q[7:1] == DEV_ADDR_ID[7:1]);
    wire addrDiag = (shift_q[7:1] == DEV_ADDR_DIAG[7:1]);
    wire wrStrobe = sclFall && (state_q == ST_WR) && byteDone;
    wire statusWr = wrStrobe && memSel_q && (ptr_q == STATUS_OFS);

    // Pin side state and registered outputs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pinPrev_q <= 1'b1;
            faultLat_q <= 1'b0;
            laserOn_q <= 1'b0;
            rxLost_q <= 1'b0;
            lowDrive_q <= 1'b0;
            softDis_q <= 1'b0;
            faultOe_q <= 1'b1;
        end else begin
            pinPrev_q <= pinS;
            faultLat_q <= faultLat_d;
            faultOe_q <= !faultLat_d;
            laserOn_q <= laserOn_d;
            rxLost_q <= rxAbsS;
            if (statusWr) begin
                softDis_q <= shift_q[BIT_SOFT_DIS];
            end
        end
    end

    // Memory arrays carry no reset; the status byte lives in flops instead
    always_ff @(posedge clk_sys) begin
        if (wrStrobe && !memSel_q) begin
            idMem[ptr_q] <= shift_q;
        end
        if (wrStrobe && memSel_q && ptr_q != STATUS_OFS) begin
            diagMem[ptr_q] <= shift_q;
        end
    end

    // Two-wire slave; samples on rising clock, drives on falling clock
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            memSel_q <= 1'b0;
            readMode_q <= 1'b0;
            masterAck_q <= 1'b0;
            sdaOe_q <= 1'b0;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            if (startDet) begin
                state_q <= ST_ADDR;
                bitCnt_q <= 4'h0;
                sdaOe_q <= 1'b0;
            end else if (stopDet) begin
                state_q <= ST_IDLE;
                sdaOe_q <= 1'b0;
            end else if (sclRise) begin
                if (state_q == ST_ADDR || state_q == ST_PTR ||
                    state_q == ST_WR) begin
                    shift_q <= {shift_q[6:0], sdaS};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
                if (state_q == ST_RD_ACK) begin
                    masterAck_q <= !sdaS;
                end
            end else if (sclFall) begin
                unique case (state_q)
                    ST_IDLE: begin
                    end
                    ST_ADDR: begin
                        if (byteDone && (addrId || addrDiag)) begin
                            memSel_q <= addrDiag;
                            readMode_q <= shift_q[0];
                            state_q <= ST_ADDR_ACK;
                            sdaOe_q <= 1'b1;
                        end else if (byteDone) begin
                            state_q <= ST_IDLE; // Other device on the bus
                        end
                    end
                    ST_ADDR_ACK, ST_RD_ACK: begin
                        bitCnt_q <= 4'h1;
                        if (state_q == ST_ADDR_ACK && !readMode_q) begin
                            state_q <= ST_PTR;
                            bitCnt_q <= 4'h0;
                            sdaOe_q <= 1'b0;
                        end else if (state_q == ST_RD_ACK && !masterAck_q) begin
                            state_q <= ST_IDLE; // Master ended the read
                            sdaOe_q <= 1'b0;
                        end else begin
                            state_q <= ST_RD;
                            shift_q <= rdByte;
                            sdaOe_q <= !rdByte[7];
                        end
                    end
                    ST_RD: begin
                        if (byteDone) begin
                            state_q <= ST_RD_ACK;
                            sdaOe_q <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sdaOe_q <= !shift_q[6];
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                    end
                    ST_PTR: begin
                        if (byteDone) begin
                            ptr_q <= shift_q;
                            state_q <= ST_PTR_ACK;
                            sdaOe_q <= 1'b1;
                        end
                    end
                    ST_WR: begin
                        if (byteDone) begin
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= ST_WR_ACK;
                            sdaOe_q <= 1'b1;
                        end
                    end
                    ST_PTR_ACK, ST_WR_ACK: begin
                        state_q <= ST_WR;
                        bitCnt_q <= 4'h0;
                        sdaOe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-collector pins only ever pull low
    assign sdaOut = lowDrive_q;
    assign sdaOe = sdaOe_q;
    assign txLaserEn = laserOn_q;
    assign txFaultOut = lowDrive_q;
    assign txFaultOe = faultOe_q;
    assign receiveSignalLost = rxLost_q;

    // Address match held one cycle for the acknowledge check
    logic addrDiag_p;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            addrDiag_p <= 1'b0;
        end else begin
            addrDiag_p <= addrDiag;
        end
    end

    // Checks on the pin side and the bus slave, all on the system clock
    default clocking checkClk @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence addrSeen_s;
        state_q == ST_ADDR && byteDone && sclFall && !startDet && !stopDet;
    endsequence
    sequence addrMatch_s;
        addrSeen_s ##0 (addrId || addrDiag);
    endsequence

    pin_disable_a: assert property (
        (pinS || softDis_q) |=> !txLaserEn)
        else $error("laser on while disabled");
    pin_enable_a: assert property (
        (!pinS && !softDis_q && !faultLat_q && !faultS) |=> txLaserEn)
        else $error("laser off with no disable cause");
    soft_write_a: assert property (
        statusWr |=> softDis_q == $past(shift_q[BIT_SOFT_DIS]))
        else $error("soft shutdown bit not written");
    reset_off_a: assert property (
        $past(sys_rst) |-> !txLaserEn ##1 !txLaserEn)
        else $error("laser on right after reset");
    fault_set_a: assert property (
        faultS |=> faultLat_q && !txFaultOe ##1 !txLaserEn)
        else $error("fault not latched or laser left on");
    fault_hold_a: assert property (
        (faultLat_q && !pinFall) |=> faultLat_q)
        else $error("fault cleared without pin toggle");
    fault_clear_a: assert property (
        (faultLat_q && pinFall && !faultS) |=> !faultLat_q && txFaultOe)
        else $error("pin toggle did not clear fault");
    rx_lost_a: assert property (
        rxAbsS |=> receiveSignalLost && statusByte[BIT_RX_LOST])
        else $error("signal lost not reported");
    addr_ack_a: assert property (
        addrMatch_s |=> state_q == ST_ADDR_ACK && sdaOe &&
            memSel_q == addrDiag_p)
        else $error("own address not acknowledged");
endmodule
`default_nettype wire

// *** rtl/omcs_pkg.sv ***
// Constants and types for the optical module control and status block.
// Assumes one 125 MHz clock; all pins arrive asynchronously.
package omcs_pkg;
    localparam logic [7:0] DEV_ADDR_ID = 8'hA0;
    localparam logic [7:0] DEV_ADDR_DIAG = 8'hA2;
    localparam logic [7:0] STATUS_OFS = 8'h6E;
    localparam int BIT_PIN_STATE = 7;
    localparam int BIT_SOFT_DIS = 6;
    localparam int BIT_TX_FAULT = 2;
    localparam int BIT_RX_LOST = 1;
    // Monitor words, most significant byte first
    localparam logic [7:0] MON_TEMP_OFS = 8'h60;
    localparam logic [7:0] MON_VCC_OFS = 8'h62;
    localparam logic [7:0] MON_BIAS_OFS = 8'h64;
    localparam logic [7:0] MON_TXPWR_OFS = 8'h66;
    localparam logic [7:0] MON_RXPWR_OFS = 8'h68;
    // Synchroniser lanes and their reset levels
    localparam int SYNC_W = 5;
    localparam int IX_TXDIS = 0;
    localparam int IX_FAULT = 1;
    localparam int IX_RXABS = 2;
    localparam int IX_SCL = 3;
    localparam int IX_SDA = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = 5'h19;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] vcc;
        logic [15:0] bias;
        logic [15:0] txPower;
        logic [15:0] rxPower;
    } omcs_mon_s;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } omcs_state_e;
endpackage

// *** test/omcs_host.sv ***
// Host board model: pin drivers with board pulls and a two-wire master.
// Assumes one clock shared with the module; bus idles with both lines high.
`timescale 1ns/100ps
`default_nettype none
module omcs_host (
    input wire logic clk_sys,
    input wire logic disDrive,
    input wire logic disVal,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic txFaultOut,
    input wire logic txFaultOe,
    output logic sclIn,
    output logic sdaIn,
    output logic txDisablePin,
    output logic faultLine
);
    logic scl = 1'b1;
    logic sdaLow = 1'b0;
    int half = 6;
    // Undriven shutdown pin floats to disabled through the pull-up
    assign txDisablePin = disDrive ? disVal : 1'b1;
    // Open-drain lines resolved against board pull-ups
    assign sdaIn = !(sdaLow || (sdaOe && !sdaOut));
    assign faultLine = !(txFaultOe && !txFaultOut);
    assign sclIn = scl;

    // Phase length; raised by the bench to mimic a slow host
    task automatic ph();
        repeat (half) @(posedge clk_sys);
    endtask
    // One clock pulse, line sampled late in the high phase
    task automatic bitx(input logic b, output logic r);
        sdaLow <= !b;
        ph();
        scl <= 1'b1;
        ph();
        r = sdaIn;
        scl <= 1'b0;
        ph();
    endtask
    // Also serves as repeated start, entered with the clock low
    task automatic start();
        sdaLow <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sdaLow <= 1'b1;
        ph();
        scl <= 1'b0;
        ph();
    endtask
    task automatic stop();
        sdaLow <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sdaLow <= 1'b0;
        ph();
    endtask
    // Eight bits MSB first, then the ninth driven as b9
    task automatic xbyte(input logic [7:0] d, input logic b9,
                         output logic [7:0] r, output logic r9);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r[i]);
        end
        bitx(b9, r9);
    endtask
    // Pointer then one data byte; ack low if any byte went unanswered
    task automatic wr(input logic [7:0] dev, ofs, dat, output logic ack);
        logic [7:0] r;
        logic a0, a1, a2;
        start();
        xbyte(dev, 1'b1, r, a0);
        xbyte(ofs, 1'b1, r, a1);
        xbyte(dat, 1'b1, r, a2);
        stop();
        ack = !(a0 | a1 | a2);
    endtask
    task automatic rd(input logic [7:0] dev, ofs, output logic [7:0] dat);
        logic [7:0] r;
        logic a;
        start();
        xbyte(dev, 1'b1, r, a);
        xbyte(ofs, 1'b1, r, a);
        start();
        xbyte(dev | 8'h01, 1'b1, r, a);
        xbyte(8'hFF, 1'b1, dat, a); // Nack ends the read
        stop();
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the control and status block.
// Assumes the host model as bus master and a 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
    import omcs_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic disDrive = 1'b0;
    logic disVal = 1'b1;
    logic laserFaultDet = 1'b0;
    logic rxModAbsent = 1'b0;
    omcs_mon_s monitors = '0;
    logic sclIn, sdaIn, sdaOut, sdaOe, txDisablePin, faultLine;
    logic txLaserEn, txFaultOut, txFaultOe, receiveSignalLost;
    int n_fail = 0;
    int compares = 0;
    int expSoft = 0;
    int expFault = 0;
    logic [7:0] rv, wv, ofs;
    logic [15:0] w;
    logic ack;

    omcs_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .txDisablePin(txDisablePin), .laserFaultDet(laserFaultDet),
        .rxModAbsent(rxModAbsent), .monitors(monitors), .sclIn(sclIn),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .txLaserEn(txLaserEn), .txFaultOut(txFaultOut),
        .txFaultOe(txFaultOe), .receiveSignalLost(receiveSignalLost));
    omcs_host i_host (.clk_sys(clk_sys), .disDrive(disDrive),
        .disVal(disVal), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .txFaultOut(txFaultOut), .txFaultOe(txFaultOe), .sclIn(sclIn),
        .sdaIn(sdaIn), .txDisablePin(txDisablePin), .faultLine(faultLine));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // Reference status byte from pin levels and the model's flags
    function automatic logic [7:0] expStatus();
        return {txDisablePin, expSoft[0], 3'h0, expFault[0], rxModAbsent,
                1'b0};
    endfunction
    // Pins settle three edges after a change; one spare edge
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask
    // Pin outputs against the model, then the live status byte
    task automatic chkPins();
        `CHK(txLaserEn, !(txDisablePin || expSoft || expFault))
        `CHK(faultLine, expFault[0])
        `CHK(receiveSignalLost, rxModAbsent)
        i_host.rd(DEV_ADDR_DIAG, STATUS_OFS, rv);
        `CHK(rv, expStatus())
    endtask
    task automatic conclude();
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 13k cycles of traffic
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end

    initial begin
        void'($urandom(32'h8C379A0B));
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chkPins(); // Undriven pin keeps laser off
        disDrive <= 1'b1;
        disVal <= 1'b0; // Host not using the pin ties it low
        settle();
        chkPins();
        // All ones written: only the soft shutdown bit may take
        i_host.wr(DEV_ADDR_DIAG, STATUS_OFS, 8'hFF, ack);
        expSoft = 1;
        settle();
        chkPins();
        i_host.half = 9;
        i_host.wr(DEV_ADDR_DIAG, STATUS_OFS, 8'h00, ack);
        expSoft = 0;
        i_host.half = 4;
        for (int i = 0; i < 2; i++) begin
            rxModAbsent <= !rxModAbsent;
            settle();
            chkPins();
        end
        // Fault, clear refused while detector high, then a real toggle
        laserFaultDet <= 1'b1;
        expFault = 1;
        settle();
        chkPins();
        disVal <= 1'b1;
        settle();
        disVal <= 1'b0;
        settle();
        laserFaultDet <= 1'b0;
        settle();
        chkPins(); // Still latched with the cause gone
        disVal <= 1'b1;
        settle();
        chkPins();
        disVal <= 1'b0;
        expFault = 0;
        settle();
        settle();
        chkPins(); // Toggle clears and laser retries
        // Live monitor words, high byte at the even offset
        monitors <= {16'($urandom), 16'($urandom), 16'($urandom),
                     16'($urandom), 16'($urandom)};
        settle();
        for (int k = 0; k < 5; k++) begin
            w = monitors[79 - 16 * k -: 16];
            i_host.rd(DEV_ADDR_DIAG, MON_TEMP_OFS + 8'(2 * k), rv);
            `CHK(rv, w[15:8])
            i_host.rd(DEV_ADDR_DIAG, MON_TEMP_OFS + 8'(2 * k + 1), rv);
            `CHK(rv, w[7:0])
        end
        // Same offset in both memories must hold different bytes
        wv = 8'($urandom);
        ofs = 8'($urandom_range(32'h5F, 0));
        i_host.wr(DEV_ADDR_ID, ofs, wv, ack);
        `CHK(ack, 1'b1)
        i_host.wr(DEV_ADDR_DIAG, ofs, ~wv, ack);
        i_host.rd(DEV_ADDR_ID, ofs, rv);
        `CHK(rv, wv)
        i_host.rd(DEV_ADDR_DIAG, ofs, rv);
        `CHK(rv, ~wv)
        i_host.wr(8'hA4, ofs, wv, ack);
        `CHK(ack, 1'b0) // Foreign address left unanswered
        conclude();
    end
endmodule
`default_nettype wire
